// *** rtl/rdw_defs.vh ***
`ifndef RDW_DEFS_VH
`define RDW_DEFS_VH
// register offsets (byte addresses on the plain port)
`define RDW_ADDR_W 8
`define RDW_OFF_SUBSYS 8'h2c
`define RDW_OFF_GNTLAT 8'h3e
`define RDW_OFF_MFR 8'h8c
`define RDW_OFF_PMCSR 8'ha4
`define RDW_OFF_MISC 8'hf0
`define RDW_OFF_ENH 8'hf4
`define RDW_OFF_SOCKST 8'h10
`define RDW_OFF_CTRL 8'hc0
`define RDW_OFF_STAT 8'hc4
`define RDW_OFF_ORD 8'hc8
// pmcsr fields
`define RDW_PM_STAT 15
`define RDW_PM_EN 8
// socket status wake context mask (bits 6,5,4,2,1,0)
`define RDW_SOCK_CTX 32'h0000_0077
// control register fields
`define RDW_C_RING_WAKE_ENABLE 0
`define RDW_C_RING_ROUTE_SELECT 1
`define RDW_C_RING_OUTPUT_ENABLE 2
`define RDW_C_CB 3
`define RDW_C_STS_EN 4
`define RDW_C_INTERROG 5
`define RDW_C_SER_EN 6
// defaults
`define RDW_DEF_ZERO 32'h0000_0000
`define RDW_DEF_GNTLAT 32'h0000_0000
// voltage sense toggle divider
`define RDW_VS_DIV 16'h0063
`endif

// *** rtl/rdw_sts_pin.v ***
`timescale 1ns/1ns
module rdw_sts_pin (
	// clock and reset
	input wire clk,
	input wire rst,
	// request
	input wire assert_req,
	// pin
	output reg pin_o,
	output reg pin_oe
);
reg was_on;
always @(posedge clk) begin
	if (rst) begin
		pin_o <= 1'b1;
		pin_oe <= 1'b0;
		was_on <= 1'b0;
	end else if (assert_req) begin
		pin_o <= 1'b0;
		pin_oe <= 1'b1;
		was_on <= 1'b1;
	end else if (was_on) begin
		// one cycle driven high so the bus line is not left floating low
		pin_o <= 1'b1;
		pin_oe <= 1'b1;
		was_on <= 1'b0;
	end else begin
		pin_o <= 1'b1;
		pin_oe <= 1'b0;
	end
end
endmodule

// *** rtl/rdw_sync2.v ***
`timescale 1ns/1ns
module rdw_sync2 #(
	parameter W = 1
) (
	// clock
	input wire clk,
	// data
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
reg [W-1:0] meta;
always @(posedge clk) begin
	meta <= d;
	q <= meta;
end
endmodule

// *** rtl/rdw_top.v ***
// Function
// - global-only bits clear only on global reset
// - wake context kept on bus reset if enabled
// - sleep input gates both resets
// - link registers cleared by global reset only
// - multifunction routing register fully global-only
// - power control bits 15, 8 are wake context
// - socket status bits 6,5,4,2,1,0 are context
// - wake status latches on each rising edge of the selected card event
// - ring route zero drives raw event both pins
// - otherwise wake enable drives latched event
// - route one: pin7 raw, wake pin latched
// - 16-bit ring needs ring wake enable
// - sustained signal driven high before release
// - voltage sense low except reset, interrogation
// - sleep stops serial interrupt stream
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ns
`include "rdw_defs.vh"
module rdw_top (
	// clock and reset
	input wire SYS_CLK,
	input wire SYS_RST,
	// reset and sleep pins
	input wire GLOBAL_RESET_N,
	input wire BUS_RESET_N,
	input wire SLEEP_GATE_N,
	// card events
	input wire CARD_STATUS_CHANGE,
	input wire RING_INDICATE,
	// register port
	input wire [`RDW_ADDR_W-1:0] ADDR,
	input wire [31:0] WDATA,
	input wire WR,
	input wire RD,
	output reg [31:0] RDATA,
	// wake pins (open drain, enable high drives low)
	output reg WAKE_OUT_PIN_O,
	output reg WAKE_OUT_PIN_OE,
	output reg MULTI_FUNCTION_PIN7_O,
	output reg MULTI_FUNCTION_PIN7_OE,
	// sustained tristate line
	input wire STS_REQ,
	output reg SUSTAINED_TRISTATE_O,
	output reg SUSTAINED_TRISTATE_OE,
	// voltage sense
	output reg [1:0] VOLTAGE_SENSE_PINS_O,
	output reg [1:0] VOLTAGE_SENSE_PINS_OE,
	// serial interrupt stream
	input wire IRQ_REQ,
	output reg SERIAL_INTERRUPT_STREAM_O
);
////////////////////////////////////////////////////////////////
// pin synchronisers
wire [4:0] sync_q;
rdw_sync2 #(.W(5)) u_sync (
	.clk(SYS_CLK),
	.d({GLOBAL_RESET_N, BUS_RESET_N, SLEEP_GATE_N,
		CARD_STATUS_CHANGE, RING_INDICATE}),
	.q(sync_q)
);
wire g_n = sync_q[4];
wire b_n = sync_q[3];
wire sleep_n = sync_q[2];
wire csc = sync_q[1];
wire ri = sync_q[0];
// sleep blocks both resets while asserted
wire g_rst = ~g_n & sleep_n;
wire b_rst = ~b_n & sleep_n;
////////////////////////////////////////////////////////////////
// reset classes
// global-only: cleared by core reset or an ungated global reset
// wake context: kept across bus reset while wake is enabled
// ordinary: cleared by any ungated reset
reg [31:0] subsys; // global-only
reg [31:0] gntlat;
reg [31:0] mfr;
reg [31:0] misc;
reg [31:0] enh;
reg [31:0] ctrl;
reg [31:0] ord;
reg pm_stat;
reg pm_en;
reg [31:0] sockst;
wire wake_en = pm_en;
// class clear terms
wire clr_glob = SYS_RST | g_rst;
wire clr_ctx = clr_glob | (b_rst & ~wake_en);
wire clr_ord = clr_glob | b_rst;
wire ring_wake_enable = ctrl[`RDW_C_RING_WAKE_ENABLE];
wire ring_route_select = ctrl[`RDW_C_RING_ROUTE_SELECT];
wire ring_output_enable = ctrl[`RDW_C_RING_OUTPUT_ENABLE];
wire cb_card = ctrl[`RDW_C_CB];
// event source: cardbus status change, or ring gated by ring enable
wire ev_raw = cb_card ? csc : (ri & ring_wake_enable);
wire ev_any = cb_card ? csc : ri;
reg ev_d;
wire ev_rise = ev_any & ~ev_d;
function wsel;
	input [31:0] a;
	input [`RDW_ADDR_W-1:0] off;
	begin
		wsel = WR & (ADDR == off);
	end
endfunction
function [31:0] merge;
	input [31:0] old;
	input [31:0] nw;
	input [31:0] m;
	begin
		merge = (old & ~m) | (nw & m);
	end
endfunction
////////////////////////////////////////////////////////////////
// global-only registers
always @(posedge SYS_CLK) begin
	if (clr_glob) begin
		subsys <= `RDW_DEF_ZERO;
		gntlat <= `RDW_DEF_GNTLAT;
		mfr <= `RDW_DEF_ZERO;
		misc <= `RDW_DEF_ZERO;
		enh <= `RDW_DEF_ZERO;
	end else begin
		if (wsel(0, `RDW_OFF_SUBSYS))
			subsys <= WDATA;
		if (wsel(0, `RDW_OFF_GNTLAT))
			gntlat <= WDATA;
		if (wsel(0, `RDW_OFF_MFR))
			mfr <= WDATA;
		if (wsel(0, `RDW_OFF_MISC))
			misc <= WDATA;
		if (wsel(0, `RDW_OFF_ENH))
			enh <= WDATA;
	end
end
////////////////////////////////////////////////////////////////
// wake context bits
always @(posedge SYS_CLK) begin
	if (clr_ctx) begin
		pm_en <= 1'b0;
		pm_stat <= 1'b0;
		sockst <= `RDW_DEF_ZERO;
		ev_d <= 1'b0;
	end else begin
		ev_d <= ev_any;
		if (wsel(0, `RDW_OFF_PMCSR))
			pm_en <= WDATA[`RDW_PM_EN];
		// status set wins over write-one clear
		if (ev_rise)
			pm_stat <= 1'b1;
		else if (wsel(0, `RDW_OFF_PMCSR) & WDATA[`RDW_PM_STAT])
			pm_stat <= 1'b0;
		// only the context bits are writable, the rest read zero
		if (wsel(0, `RDW_OFF_SOCKST))
			sockst <= merge(sockst, WDATA, `RDW_SOCK_CTX);
	end
end
////////////////////////////////////////////////////////////////
// ordinary registers
always @(posedge SYS_CLK) begin
	if (clr_ord) begin
		ctrl <= `RDW_DEF_ZERO;
		ord <= `RDW_DEF_ZERO;
	end else begin
		if (wsel(0, `RDW_OFF_CTRL))
			ctrl <= WDATA;
		if (wsel(0, `RDW_OFF_ORD))
			ord <= WDATA;
	end
end
////////////////////////////////////////////////////////////////
// read port, data one cycle after strobe
// unmapped addresses read zero; idle cycles read zero too
always @(posedge SYS_CLK) begin
	if (SYS_RST) begin
		RDATA <= `RDW_DEF_ZERO;
	end else if (RD) begin
		case (ADDR)
		`RDW_OFF_SUBSYS: RDATA <= subsys;
		`RDW_OFF_GNTLAT: RDATA <= gntlat;
		`RDW_OFF_MFR: RDATA <= mfr;
		`RDW_OFF_MISC: RDATA <= misc;
		`RDW_OFF_ENH: RDATA <= enh;
		`RDW_OFF_PMCSR: begin
			RDATA <= `RDW_DEF_ZERO;
			RDATA[`RDW_PM_STAT] <= pm_stat;
			RDATA[`RDW_PM_EN] <= pm_en;
		end
		`RDW_OFF_SOCKST: RDATA <= sockst & `RDW_SOCK_CTX;
		`RDW_OFF_CTRL: RDATA <= ctrl;
		`RDW_OFF_STAT: RDATA <= {27'h0, ~sleep_n, b_rst, g_rst,
			ev_any, pm_stat};
		`RDW_OFF_ORD: RDATA <= ord;
		default: RDATA <= `RDW_DEF_ZERO;
		endcase
	end else begin
		RDATA <= `RDW_DEF_ZERO;
	end
end
////////////////////////////////////////////////////////////////
// routing mode decode
wire mode_raw = ring_wake_enable & ring_output_enable & ~ring_route_select;
wire mode_split = ring_wake_enable & ring_output_enable & ring_route_select;
// a 16-bit card without ring enable never reaches a pin
wire src_ok = cb_card | ring_wake_enable;
// raw routing owns the wake pin, so the latch is kept off it
wire latch_ok = ~(ring_output_enable & ~ring_route_select) & src_ok;
wire latched_ev = wake_en & pm_stat & latch_ok;
////////////////////////////////////////////////////////////////
// wake routing; active-low pins so drive low to signal
reg next_wake;
reg next_mf7;
always @* begin
	next_wake = 1'b0;
	next_mf7 = 1'b0;
	if (mode_raw) begin
		// unlatched event, wake enable has no say here
		next_wake = ev_raw;
		next_mf7 = ev_raw;
	end else if (mode_split) begin
		next_wake = latched_ev;
		next_mf7 = ev_raw;
	end else begin
		next_wake = latched_ev;
		next_mf7 = 1'b0;
	end
end
always @(posedge SYS_CLK) begin
	if (SYS_RST) begin
		WAKE_OUT_PIN_O <= 1'b0;
		WAKE_OUT_PIN_OE <= 1'b0;
		MULTI_FUNCTION_PIN7_O <= 1'b0;
		MULTI_FUNCTION_PIN7_OE <= 1'b0;
	end else begin
		WAKE_OUT_PIN_O <= 1'b0;
		WAKE_OUT_PIN_OE <= next_wake;
		MULTI_FUNCTION_PIN7_O <= 1'b0;
		MULTI_FUNCTION_PIN7_OE <= next_mf7;
	end
end
////////////////////////////////////////////////////////////////
// sustained tristate line
// a held request keeps the line low; needs the enable bit
wire sts_o, sts_oe;
rdw_sts_pin u_sts (
	.clk(SYS_CLK),
	.rst(SYS_RST),
	.assert_req(STS_REQ & ctrl[`RDW_C_STS_EN]),
	.pin_o(sts_o),
	.pin_oe(sts_oe)
);
always @(posedge SYS_CLK) begin
	if (SYS_RST) begin
		SUSTAINED_TRISTATE_O <= 1'b1;
		SUSTAINED_TRISTATE_OE <= 1'b0;
	end else begin
		SUSTAINED_TRISTATE_O <= sts_o;
		SUSTAINED_TRISTATE_OE <= sts_oe;
	end
end
////////////////////////////////////////////////////////////////
// voltage sense: slow toggle enable during interrogation
reg [15:0] vs_cnt;
reg vs_tog;
wire interrog = ctrl[`RDW_C_INTERROG];
wire in_reset = SYS_RST | g_rst | b_rst;
always @(posedge SYS_CLK) begin
	if (SYS_RST) begin
		vs_cnt <= 16'h0000;
		vs_tog <= 1'b0;
		VOLTAGE_SENSE_PINS_O <= 2'b00;
		VOLTAGE_SENSE_PINS_OE <= 2'b00;
	end else begin
		if (!interrog || vs_cnt == `RDW_VS_DIV)
			vs_cnt <= 16'h0000;
		else
			vs_cnt <= vs_cnt + 16'h0001;
		if (!interrog)
			vs_tog <= 1'b0;
		else if (vs_cnt == `RDW_VS_DIV)
			vs_tog <= ~vs_tog;
		if (in_reset) begin
			VOLTAGE_SENSE_PINS_O <= 2'b00;
			VOLTAGE_SENSE_PINS_OE <= 2'b00;
		end else begin
			VOLTAGE_SENSE_PINS_O <= {2{interrog & vs_tog}};
			VOLTAGE_SENSE_PINS_OE <= 2'b11;
		end
	end
end
////////////////////////////////////////////////////////////////
// serial interrupt stream; halted while sleep asserted
// idles high so a sleeping device never claims a slot
always @(posedge SYS_CLK) begin
	if (SYS_RST)
		SERIAL_INTERRUPT_STREAM_O <= 1'b1;
	else if (!sleep_n || !ctrl[`RDW_C_SER_EN])
		SERIAL_INTERRUPT_STREAM_O <= 1'b1;
	else
		SERIAL_INTERRUPT_STREAM_O <= ~IRQ_REQ;
end
endmodule

// *** test/rdw_card_model.sv ***
`timescale 1ns/1ns
module rdw_card_model (
	// clock
	input wire clk,
	// bench command: bit0 status change, bit1 ring
	input wire [1:0] ev,
	// card events
	output reg csc = 1'b0,
	output reg ri = 1'b0,
	// open drain wake line
	input wire wake_oe,
	output wire wake_line
);
	// board pull-up when nobody sinks
	assign wake_line = wake_oe ? 1'b0 : 1'b1;
	always @(posedge clk) begin
		csc <= ev[0];
		ri <= ev[1];
	end
endmodule

// *** test/rdw_top_sva.sv ***
`timescale 1ns/1ns
module rdw_top_sva (
	// clock and reset
	input wire SYS_CLK,
	input wire SYS_RST,
	// watched pins
	input wire CARD_STATUS_CHANGE,
	input wire RING_INDICATE,
	input wire WAKE_OUT_PIN_O,
	input wire MULTI_FUNCTION_PIN7_O,
	input wire MULTI_FUNCTION_PIN7_OE,
	input wire SUSTAINED_TRISTATE_O,
	input wire SUSTAINED_TRISTATE_OE,
	input wire [1:0] VOLTAGE_SENSE_PINS_OE,
	input wire SLEEP_GATE_N,
	input wire IRQ_REQ,
	input wire SERIAL_INTERRUPT_STREAM_O
);
	wire ev = CARD_STATUS_CHANGE | RING_INDICATE;
	wire so = SUSTAINED_TRISTATE_O;
	wire se = SUSTAINED_TRISTATE_OE;
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);
	property p_od;
		!WAKE_OUT_PIN_O && !MULTI_FUNCTION_PIN7_O;
	endproperty
	a_od: assert property (p_od) else $error("pin driven high");
	// sync plus register delay, so look a few cycles back
	property p_mf;
		$rose(MULTI_FUNCTION_PIN7_OE) |->
			$past(ev, 2) || $past(ev, 3) || $past(ev, 4) || $past(ev, 5);
	endproperty
	a_mf: assert property (p_mf) else $error("pin7 no event");
	property p_sh;
		se && !so |=> se;
	endproperty
	a_sh: assert property (p_sh) else $error("low then float");
	property p_sr;
		$fell(se) |-> $past(so);
	endproperty
	a_sr: assert property (p_sr) else $error("float not high");
	property p_so;
		se && so |=> !se;
	endproperty
	a_so: assert property (p_so) else $error("high too long");
	property p_vr;
		disable iff (1'b0) SYS_RST |=> VOLTAGE_SENSE_PINS_OE == 2'b00;
	endproperty
	a_vr: assert property (p_vr) else $error("sense driven");
	property p_ss;
		!SLEEP_GATE_N [*5] |-> SERIAL_INTERRUPT_STREAM_O;
	endproperty
	a_ss: assert property (p_ss) else $error("stream in sleep");
	property p_si;
		!SERIAL_INTERRUPT_STREAM_O |-> $past(IRQ_REQ);
	endproperty
	a_si: assert property (p_si) else $error("stream no req");
endmodule
bind rdw_top rdw_top_sva u_sva (.SYS_CLK, .SYS_RST, .CARD_STATUS_CHANGE,
	.RING_INDICATE, .WAKE_OUT_PIN_O, .MULTI_FUNCTION_PIN7_O,
	.MULTI_FUNCTION_PIN7_OE, .SUSTAINED_TRISTATE_O, .SUSTAINED_TRISTATE_OE,
	.VOLTAGE_SENSE_PINS_OE, .SLEEP_GATE_N, .IRQ_REQ,
	.SERIAL_INTERRUPT_STREAM_O);

// *** test/tb_top.sv ***
`timescale 1ns/1ns
`include "rdw_defs.vh"
module tb_top;
	reg clk = 0;
	reg rst = 1;
	reg g_n = 1, b_n = 1, s_n = 1, sreq = 0, irq = 0, wr = 0, rd = 0;
	reg [1:0] ev = 0;
	reg [7:0] ad = 0;
	reg [31:0] wd = 0;
	reg w, m, g;
	wire csc, ri, wl, wo, we, mo, me, so, se, ser;
	wire [1:0] vo, ve;
	wire [31:0] rdd;
	integer err_count = 0, tests_run = 0, i;
	initial forever #5 clk = ~clk;
	rdw_top dut (.SYS_CLK(clk), .SYS_RST(rst), .GLOBAL_RESET_N(g_n),
		.BUS_RESET_N(b_n), .SLEEP_GATE_N(s_n), .CARD_STATUS_CHANGE(csc),
		.RING_INDICATE(ri), .ADDR(ad), .WDATA(wd), .WR(wr), .RD(rd),
		.RDATA(rdd), .WAKE_OUT_PIN_O(wo), .WAKE_OUT_PIN_OE(we),
		.MULTI_FUNCTION_PIN7_O(mo), .MULTI_FUNCTION_PIN7_OE(me),
		.STS_REQ(sreq), .SUSTAINED_TRISTATE_O(so),
		.SUSTAINED_TRISTATE_OE(se), .VOLTAGE_SENSE_PINS_O(vo),
		.VOLTAGE_SENSE_PINS_OE(ve), .IRQ_REQ(irq),
		.SERIAL_INTERRUPT_STREAM_O(ser));
	rdw_card_model card (.clk(clk), .ev(ev), .csc(csc), .ri(ri),
		.wake_oe(we), .wake_line(wl));
	task chk(input [31:0] s, input [31:0] e);
	begin
		tests_run = tests_run + 1;
		if (s !== e) begin
			err_count = err_count + 1;
			$display("unexpected %0t %h %h", $time, s, e);
		end
	end
	endtask
	task wr32(input [7:0] a, input [31:0] d);
	begin
		@(posedge clk);
		ad <= a;
		wd <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	end
	endtask
	task rd32(input [7:0] a, input [31:0] e);
	begin
		@(posedge clk);
		ad <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 chk(rdd, e);
	end
	endtask
	// pin resets pass a synchronizer, so allow settling
	task pins(input [2:0] v);
	begin
		@(posedge clk);
		{g_n, b_n, s_n} <= v;
		repeat (6) @(posedge clk);
	end
	endtask
	task give_verdict;
	begin
		if (err_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 0;
		#1 chk({ve, vo}, 4'h0);
		wr32(`RDW_OFF_MFR, 32'hdead_beef);
		wr32(`RDW_OFF_SUBSYS, 32'h1234_5678);
		wr32(`RDW_OFF_ORD, 32'h0000_00a5);
		wr32(`RDW_OFF_SOCKST, `RDW_SOCK_CTX);
		wr32(`RDW_OFF_PMCSR, 32'h0000_0100);
		chk({ve, vo}, 4'hc);
		pins(3'b101);
		pins(3'b111);
		rd32(`RDW_OFF_MFR, 32'hdead_beef);
		rd32(`RDW_OFF_SUBSYS, 32'h1234_5678);
		rd32(`RDW_OFF_SOCKST, `RDW_SOCK_CTX);
		rd32(`RDW_OFF_PMCSR, 32'h0000_0100);
		rd32(`RDW_OFF_ORD, 32'h0);
		wr32(`RDW_OFF_ORD, 32'h0000_00a5);
		pins(3'b110);
		rd32(`RDW_OFF_STAT, 32'h0000_0010);
		pins(3'b000);
		pins(3'b110);
		pins(3'b111);
		rd32(`RDW_OFF_ORD, 32'h0000_00a5);
		pins(3'b011);
		pins(3'b111);
		rd32(`RDW_OFF_MFR, 32'h0);
		rd32(`RDW_OFF_SUBSYS, 32'h0);
		wr32(`RDW_OFF_SOCKST, `RDW_SOCK_CTX);
		pins(3'b101);
		pins(3'b111);
		rd32(`RDW_OFF_SOCKST, 32'h0);
		rd32(8'h04, 32'h0);
		for (i = 0; i < 32; i = i + 1) begin
			wr32(`RDW_OFF_CTRL, {28'h0, i[4], i[2], i[1], i[0]});
			wr32(`RDW_OFF_PMCSR, {16'h0, 1'b1, 6'h0, i[3], 8'h0});
			g = i[4] | i[0];
			w = g & (i[2] & !i[1] ? i[0] : i[3]);
			m = g & i[0] & i[2];
			ev <= i[4] ? 2'b01 : 2'b10;
			repeat (6) @(posedge clk);
			chk({me, !wl}, {m, w});
			rd32(`RDW_OFF_PMCSR, {16'h0, 1'b1, 6'h0, i[3], 8'h0});
			ev <= 0;
			repeat (6) @(posedge clk);
			chk({me, !wl}, {1'b0, g & i[3] & !(i[2] & !i[1])});
		end
		wr32(`RDW_OFF_CTRL, 32'h0000_0020);
		repeat (102) @(posedge clk);
		#1 chk(vo, 2'h3);
		wr32(`RDW_OFF_CTRL, 32'h0000_0050);
		sreq <= 1;
		irq <= 1;
		repeat (4) @(posedge clk);
		chk({se, so, ser}, 3'b100);
		sreq <= 0;
		s_n <= 0;
		repeat (8) @(posedge clk);
		chk({se, ser}, 2'b01);
		rst <= 1;
		@(posedge clk);
		#1 chk({ve, ser}, 3'b001);
		rst <= 0;
		give_verdict;
	end
endmodule
